// [src/acg_defs.vh]
// Constants for the audio clock generator power and lock block
`ifndef ACG_DEFS_VH
`define ACG_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ACG_ADDR_LOCK_STATUS   16'hF027
`define ACG_ADDR_POWER_GATING  16'hF050
`define ACG_LOCK_STATUS_RESET  16'h0000
`define ACG_POWER_GATING_RESET 16'h0000
`define ACG_LOCK_FLAG_BIT      0
`define ACG_GEN1_PWR_BIT       10
`define ACG_GEN2_PWR_BIT       11
`define ACG_GEN3_PWR_BIT       12

// ----------------------------------------------------------------
// Clock source select codes for pins and the processing core
// ----------------------------------------------------------------
`define ACG_SEL_NONE           2'h0
`define ACG_SEL_GEN1           2'h1
`define ACG_SEL_GEN2           2'h2
`define ACG_SEL_GEN3           2'h3

// ----------------------------------------------------------------
// Lock detector
// ----------------------------------------------------------------
`define ACG_LOCK_MATCHES       4'h4
`define ACG_PERIOD_MAX         16'hFFFF

// ----------------------------------------------------------------
// Generator dividers (system clock cycles per half bit clock, bits per frame)
// ----------------------------------------------------------------
`define ACG_GEN1_HALF_DIV      16'h0008
`define ACG_GEN2_HALF_DIV      16'h000C
`define ACG_GEN3_HALF_DIV      16'h0004
`define ACG_FRAME_BITS         8'h40

`endif

// [src/acg_clock_gen.v]
// One audio clock generator: bit clock, frame clock and frame start pulse
`timescale 1ns/1ns
`default_nettype none
`include "acg_defs.vh"

module acg_clock_gen #(
    parameter [15:0] HALF_DIV   = 16'h0008,
    parameter [7:0]  FRAME_BITS = 8'h40
) (
    input  wire mclk_in,
    input  wire reset_n_in,
    input  wire enable_in,
    output reg  bit_clock_out,
    output reg  frame_clock_out,
    output reg  frame_start_out
);

    reg [15:0] div_cnt_r;
    reg [7:0]  bit_cnt_r;

    // Divider chain; powered off holds everything low so pins see a clean low
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_cnt_r       <= 16'h0000;
            bit_cnt_r       <= 8'h00;
            bit_clock_out   <= 1'b0;
            frame_clock_out <= 1'b0;
            frame_start_out <= 1'b0;
        end else if (!enable_in) begin
            div_cnt_r       <= 16'h0000;
            bit_cnt_r       <= 8'h00;
            bit_clock_out   <= 1'b0;
            frame_clock_out <= 1'b0;
            frame_start_out <= 1'b0;
        end else begin
            frame_start_out <= 1'b0;
            if (div_cnt_r == HALF_DIV - 16'h0001) begin
                div_cnt_r     <= 16'h0000;
                bit_clock_out <= ~bit_clock_out;
                // Bit boundary on the falling edge of the bit clock
                if (bit_clock_out) begin
                    if (bit_cnt_r == FRAME_BITS - 8'h01) begin
                        bit_cnt_r       <= 8'h00;
                        frame_clock_out <= 1'b0;
                        frame_start_out <= 1'b1;
                    end else begin
                        bit_cnt_r <= bit_cnt_r + 8'h01;
                        if (bit_cnt_r == (FRAME_BITS >> 1) - 8'h01) begin
                            frame_clock_out <= 1'b1;
                        end
                    end
                end
            end else begin
                div_cnt_r <= div_cnt_r + 16'h0001;
            end
        end
    end

endmodule // acg_clock_gen
`default_nettype wire

// [src/acg_lock_detect.v]
// Lock detector for the high precision generator's reference
`timescale 1ns/1ns
`default_nettype none
`include "acg_defs.vh"

module acg_lock_detect (
    input  wire mclk_in,
    input  wire reset_n_in,
    input  wire enable_in,
    input  wire ref_select_in,
    input  wire pll_ref_in,
    input  wire ext_ref_in,
    output reg  locked_out
);

    reg        ref_prev_r;
    reg        sel_prev_r;
    reg [15:0] period_cnt_r;
    reg [15:0] last_period_r;
    reg [3:0]  match_cnt_r;
    wire       ref_now;
    wire       ref_edge;

    // Same check for either source, only the tap changes
    assign ref_now  = ref_select_in ? ext_ref_in : pll_ref_in;
    assign ref_edge = ref_now & ~ref_prev_r;

    // Lock once several equal reference periods follow each other
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ref_prev_r    <= 1'b0;
            sel_prev_r    <= 1'b0;
            period_cnt_r  <= 16'h0000;
            last_period_r <= 16'h0000;
            match_cnt_r   <= 4'h0;
            locked_out    <= 1'b0;
        end else begin
            ref_prev_r <= ref_now;
            sel_prev_r <= ref_select_in;
            // Source swap restarts acquisition: old history is meaningless
            if (!enable_in || (ref_select_in != sel_prev_r)) begin
                period_cnt_r  <= 16'h0000;
                last_period_r <= 16'h0000;
                match_cnt_r   <= 4'h0;
                locked_out    <= 1'b0;
            end else if (ref_edge) begin
                period_cnt_r  <= 16'h0001;
                last_period_r <= period_cnt_r;
                if ((period_cnt_r == last_period_r) && (period_cnt_r != 16'h0000)) begin
                    if (match_cnt_r != `ACG_LOCK_MATCHES) begin
                        match_cnt_r <= match_cnt_r + 4'h1;
                    end else begin
                        locked_out <= 1'b1;
                    end
                end else begin
                    match_cnt_r <= 4'h0;
                    locked_out  <= 1'b0;
                end
            end else if (period_cnt_r == `ACG_PERIOD_MAX) begin
                // Reference lost
                match_cnt_r <= 4'h0;
                locked_out  <= 1'b0;
            end else begin
                period_cnt_r <= period_cnt_r + 16'h0001;
            end
        end
    end

endmodule // acg_lock_detect
`default_nettype wire

// [src/acg_top.v]
// Audio clock generator power gating, lock status and clock routing
`timescale 1ns/1ns
`default_nettype none
`include "acg_defs.vh"

// Summary of operation
// R1 - Status register reports high precision generator lock
// R2 - Lock valid for PLL or external reference
// R3 - Reference choice comes from separate select bit
// R4 - Lock flag bit 0, read-only, resets 0
// R5 - Power register switches off unused generators
// R6 - Power register resets to all zeros
// R7 - Bit 12 low stops high precision generator
// R8 - Blocks on stopped generator three halt
// R9 - Bit 11 low stops second generator
// R10 - Pins from stopped generator two drive low
// R11 - Blocks on stopped generator two halt
// R12 - Bit 10 low stops generator one, pins low
// R13 - Reserved bits read zero, writes ignored
module acg_top (
    input  wire        mclk_in,
    input  wire        reset_n_in,
    input  wire [15:0] reg_addr_in,
    input  wire        reg_write_in,
    input  wire        reg_read_in,
    input  wire [15:0] reg_wdata_in,
    output reg  [15:0] reg_rdata_out,
    output reg         reg_ack_out,
    input  wire        hiprec_reference_select_in,
    input  wire        pll_ref_in,
    input  wire        ext_ref_in,
    input  wire [7:0]  frame_out_sel_in,
    input  wire [7:0]  bit_out_sel_in,
    input  wire [7:0]  frame_in_sel_in,
    input  wire [7:0]  bit_in_sel_in,
    input  wire [1:0]  core_clock_sel_in,
    output reg  [3:0]  frame_clock_output_pins_out,
    output reg  [3:0]  bit_clock_output_pins_out,
    output reg  [3:0]  frame_clock_input_pins_out,
    output reg  [3:0]  frame_clock_input_pins_oe_out,
    output reg  [3:0]  bit_clock_input_pins_out,
    output reg  [3:0]  bit_clock_input_pins_oe_out,
    output reg         core_run_out,
    output reg         core_frame_tick_out
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Route one of the three generator signals by a two-bit select
    function acg_pick;
        input [1:0] sel;
        input       g1;
        input       g2;
        input       g3;
        begin
            case (sel)
                `ACG_SEL_GEN1: acg_pick = g1;
                `ACG_SEL_GEN2: acg_pick = g2;
                `ACG_SEL_GEN3: acg_pick = g3;
                default:       acg_pick = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------

    reg        first_generator_power_on_r;
    reg        second_generator_power_on_r;
    reg        hiprec_generator_power_on_r;
    wire       hiprec_lock_flag;
    wire [15:0] block_power_gating_0;
    wire [15:0] hiprec_generator_lock_status;
    wire       sel_lock;
    wire       sel_power;

    assign sel_lock  = (reg_addr_in == `ACG_ADDR_LOCK_STATUS);
    assign sel_power = (reg_addr_in == `ACG_ADDR_POWER_GATING);

    // Read images: only implemented bits show, the rest read zero
    assign block_power_gating_0 = {3'h0, hiprec_generator_power_on_r, second_generator_power_on_r,
                                   first_generator_power_on_r, 10'h000}; // R13
    assign hiprec_generator_lock_status = {15'h0000, hiprec_lock_flag}; // R1 R4 R13

    // Power register write; reserved and unmodelled bits are dropped
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            first_generator_power_on_r  <= 1'b0; // R6
            second_generator_power_on_r <= 1'b0; // R6
            hiprec_generator_power_on_r <= 1'b0; // R6
        end else if (reg_write_in && sel_power) begin
            first_generator_power_on_r  <= reg_wdata_in[`ACG_GEN1_PWR_BIT]; // R5 R12
            second_generator_power_on_r <= reg_wdata_in[`ACG_GEN2_PWR_BIT]; // R5 R9
            hiprec_generator_power_on_r <= reg_wdata_in[`ACG_GEN3_PWR_BIT]; // R5 R7
        end
    end

    // Answer every access one cycle later; writes to the lock register are ignored
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 16'h0000;
            reg_ack_out   <= 1'b0;
        end else begin
            reg_ack_out <= reg_read_in | reg_write_in;
            if (reg_read_in) begin
                if (sel_lock) begin
                    reg_rdata_out <= hiprec_generator_lock_status; // R4
                end else if (sel_power) begin
                    reg_rdata_out <= block_power_gating_0;
                end else begin
                    reg_rdata_out <= 16'h0000;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Generators
    // ----------------------------------------------------------------

    wire g1_bclk;
    wire g1_fclk;
    wire g1_tick;
    wire g2_bclk;
    wire g2_fclk;
    wire g2_tick;
    wire g3_bclk;
    wire g3_fclk;
    wire g3_tick;

    // Enables come straight from the power bits, so a cleared bit stops the divider
    acg_clock_gen #(
        .HALF_DIV   (`ACG_GEN1_HALF_DIV),
        .FRAME_BITS (`ACG_FRAME_BITS)
    ) u_gen1 (
        .mclk_in         (mclk_in),
        .reset_n_in      (reset_n_in),
        .enable_in       (first_generator_power_on_r), // R12
        .bit_clock_out   (g1_bclk),
        .frame_clock_out (g1_fclk),
        .frame_start_out (g1_tick)
    );

    acg_clock_gen #(
        .HALF_DIV   (`ACG_GEN2_HALF_DIV),
        .FRAME_BITS (`ACG_FRAME_BITS)
    ) u_gen2 (
        .mclk_in         (mclk_in),
        .reset_n_in      (reset_n_in),
        .enable_in       (second_generator_power_on_r), // R9
        .bit_clock_out   (g2_bclk),
        .frame_clock_out (g2_fclk),
        .frame_start_out (g2_tick)
    );

    acg_clock_gen #(
        .HALF_DIV   (`ACG_GEN3_HALF_DIV),
        .FRAME_BITS (`ACG_FRAME_BITS)
    ) u_gen3 (
        .mclk_in         (mclk_in),
        .reset_n_in      (reset_n_in),
        .enable_in       (hiprec_generator_power_on_r), // R7
        .bit_clock_out   (g3_bclk),
        .frame_clock_out (g3_fclk),
        .frame_start_out (g3_tick)
    );

    // Lock tracking; a powered-down generator never reports lock
    acg_lock_detect u_lock (
        .mclk_in       (mclk_in),
        .reset_n_in    (reset_n_in),
        .enable_in     (hiprec_generator_power_on_r),
        .ref_select_in (hiprec_reference_select_in), // R3
        .pll_ref_in    (pll_ref_in), // R2
        .ext_ref_in    (ext_ref_in), // R2
        .locked_out    (hiprec_lock_flag)
    );

    // ----------------------------------------------------------------
    // Pin and core routing
    // ----------------------------------------------------------------

    integer i;

    // Stopped generators already sit low, so routed pins fall low with them
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            frame_clock_output_pins_out   <= 4'h0;
            bit_clock_output_pins_out     <= 4'h0;
            frame_clock_input_pins_out    <= 4'h0;
            frame_clock_input_pins_oe_out <= 4'h0;
            bit_clock_input_pins_out      <= 4'h0;
            bit_clock_input_pins_oe_out   <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                frame_clock_output_pins_out[i] <=
                    acg_pick(frame_out_sel_in[2*i +: 2], g1_fclk, g2_fclk, g3_fclk); // R10 R12
                bit_clock_output_pins_out[i] <=
                    acg_pick(bit_out_sel_in[2*i +: 2], g1_bclk, g2_bclk, g3_bclk); // R10 R12
                frame_clock_input_pins_out[i] <=
                    acg_pick(frame_in_sel_in[2*i +: 2], g1_fclk, g2_fclk, g3_fclk); // R10 R12
                bit_clock_input_pins_out[i] <=
                    acg_pick(bit_in_sel_in[2*i +: 2], g1_bclk, g2_bclk, g3_bclk); // R10 R12
                // Input pins drive only when a generator is assigned to them
                frame_clock_input_pins_oe_out[i] <= (frame_in_sel_in[2*i +: 2] != `ACG_SEL_NONE);
                bit_clock_input_pins_oe_out[i]   <= (bit_in_sel_in[2*i +: 2] != `ACG_SEL_NONE);
            end
        end
    end

    // Core run enable and per-frame tick follow the generator it is clocked from
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            core_run_out        <= 1'b0;
            core_frame_tick_out <= 1'b0;
        end else begin
            core_run_out <= acg_pick(core_clock_sel_in, first_generator_power_on_r,
                                     second_generator_power_on_r, hiprec_generator_power_on_r); // R8 R11
            core_frame_tick_out <= acg_pick(core_clock_sel_in, g1_tick, g2_tick, g3_tick); // R8 R11
        end
    end

endmodule // acg_top
`default_nettype wire

// [test/acg_top_assertions.sv]
// Concurrent checks on the ports of the audio clock generator block
`timescale 1ns/1ns
`default_nettype none
module acg_top_chk (
    input wire logic        mclk_in,
    input wire logic        reset_n_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic        reg_write_in,
    input wire logic        reg_read_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic        reg_ack_out,
    input wire logic [7:0]  frame_out_sel_in,
    input wire logic [7:0]  bit_out_sel_in,
    input wire logic [7:0]  frame_in_sel_in,
    input wire logic [7:0]  bit_in_sel_in,
    input wire logic [1:0]  core_clock_sel_in,
    input wire logic [3:0]  frame_clock_output_pins_out,
    input wire logic [3:0]  bit_clock_output_pins_out,
    input wire logic [3:0]  frame_clock_input_pins_out,
    input wire logic [3:0]  frame_clock_input_pins_oe_out,
    input wire logic [3:0]  bit_clock_input_pins_out,
    input wire logic [3:0]  bit_clock_input_pins_oe_out,
    input wire logic        core_run_out,
    input wire logic        core_frame_tick_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    logic [2:0]  pwr_r;
    logic [33:0] sel_r;
    logic        run_r;
    logic [1:0]  off_r [1:3];
    logic [3:0]  hi_w [1:3];
    // Pins whose two-bit select equals g
    function automatic logic [3:0] hit(input logic [7:0] s, input logic [1:0] g);
        for (int i = 0; i < 4; i++)
            hit[i] = (s[2*i+:2] == g);
    endfunction
    // Shadow power bits; off count saturates at 2, enough for the two-stage pin pipeline
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwr_r <= 3'h0;
            sel_r <= '0;
            run_r <= 1'b0;
            for (int g = 1; g < 4; g++)
                off_r[g] <= 2'h2;
        end else begin
            if (reg_write_in && reg_addr_in == 16'hF050)
                pwr_r <= reg_wdata_in[12:10];
            sel_r <= {core_clock_sel_in, bit_in_sel_in, frame_in_sel_in, bit_out_sel_in, frame_out_sel_in};
            run_r <= (core_clock_sel_in == 2'h0) ? 1'b0 : pwr_r[core_clock_sel_in - 2'h1];
            for (int g = 1; g < 4; g++)
                off_r[g] <= pwr_r[g-1] ? 2'h0 : ((off_r[g] == 2'h2) ? 2'h2 : off_r[g] + 2'h1);
        end
    end
    // Any pin routed from generator g that is high
    always_comb begin
        for (int g = 1; g < 4; g++)
            hi_w[g] = (hit(sel_r[7:0], 2'(g)) & frame_clock_output_pins_out) |
                      (hit(sel_r[15:8], 2'(g)) & bit_clock_output_pins_out) |
                      (hit(sel_r[23:16], 2'(g)) & frame_clock_input_pins_out) |
                      (hit(sel_r[31:24], 2'(g)) & bit_clock_input_pins_out);
    end
    AST_ACK: assert property ((reg_write_in || reg_read_in) |=> reg_ack_out)
        else $error("no ack after strobe");
    AST_LOCK_RSV: assert property (reg_read_in && reg_addr_in == 16'hF027 |=> reg_rdata_out[15:1] == 15'h0000)
        else $error("lock status upper bits not zero");
    AST_PWR_RSV: assert property (reg_read_in && reg_addr_in == 16'hF050 |=>
        reg_rdata_out[15:13] == 3'h0 && reg_rdata_out[9:0] == 10'h000) else $error("power reserved bits not zero");
    AST_LOCK_OFF: assert property (reg_read_in && reg_addr_in == 16'hF027 && off_r[3] == 2'h2 |=> !reg_rdata_out[0])
        else $error("lock reported while generator three off");
    AST_CORE_RUN: assert property (core_run_out == run_r)
        else $error("core run does not follow selected power bit");
    AST_TICK: assert property (core_frame_tick_out |=> !core_frame_tick_out)
        else $error("core frame tick longer than one cycle");
    AST_OE: assert property ({frame_clock_input_pins_oe_out, bit_clock_input_pins_oe_out} ==
        {~hit(sel_r[23:16], 2'h0), ~hit(sel_r[31:24], 2'h0)}) else $error("pin drive enable wrong");
    AST_GEN1_LOW: assert property (off_r[1] == 2'h2 |-> hi_w[1] == 4'h0)
        else $error("pin high from stopped generator one");
    AST_GEN2_LOW: assert property (off_r[2] == 2'h2 |-> hi_w[2] == 4'h0)
        else $error("pin high from stopped generator two");
    AST_GEN3_LOW: assert property (off_r[3] == 2'h2 |-> hi_w[3] == 4'h0)
        else $error("pin high from stopped generator three");
endmodule // acg_top_chk
bind acg_top acg_top_chk i_acg_top_chk (.mclk_in, .reset_n_in, .reg_addr_in, .reg_write_in, .reg_read_in,
    .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .frame_out_sel_in, .bit_out_sel_in, .frame_in_sel_in,
    .bit_in_sel_in, .core_clock_sel_in, .frame_clock_output_pins_out, .bit_clock_output_pins_out,
    .frame_clock_input_pins_out, .frame_clock_input_pins_oe_out, .bit_clock_input_pins_out,
    .bit_clock_input_pins_oe_out, .core_run_out, .core_frame_tick_out);
`default_nettype wire

// [test/acg_top_tb.sv]
// Self-checking bench for the audio clock generator block
`timescale 1ns/1ns
`default_nettype none
module acg_top_tb;
    logic        mclk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic        reg_write_in = 1'b0;
    logic        reg_read_in = 1'b0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        hiprec_reference_select_in = 1'b0;
    logic        pll_ref_in = 1'b0;
    logic        ext_ref_in = 1'b0;
    logic [7:0]  frame_out_sel_in = 8'h00, bit_out_sel_in = 8'h00, frame_in_sel_in = 8'h00, bit_in_sel_in = 8'h00;
    logic [1:0]  core_clock_sel_in = 2'h0;
    logic [15:0] reg_rdata_out;
    logic        reg_ack_out, core_run_out, core_frame_tick_out;
    logic [3:0]  frame_clock_output_pins_out, bit_clock_output_pins_out, frame_clock_input_pins_out;
    logic [3:0]  frame_clock_input_pins_oe_out, bit_clock_input_pins_out, bit_clock_input_pins_oe_out;
    logic [15:0] acc;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          ref_cnt = 0;
    int          ticks;
    acg_top i_acg_top (.mclk_in, .reset_n_in, .reg_addr_in, .reg_write_in, .reg_read_in, .reg_wdata_in,
        .reg_rdata_out, .reg_ack_out, .hiprec_reference_select_in, .pll_ref_in, .ext_ref_in, .frame_out_sel_in,
        .bit_out_sel_in, .frame_in_sel_in, .bit_in_sel_in, .core_clock_sel_in, .frame_clock_output_pins_out,
        .bit_clock_output_pins_out, .frame_clock_input_pins_out, .frame_clock_input_pins_oe_out,
        .bit_clock_input_pins_out, .bit_clock_input_pins_oe_out, .core_run_out, .core_frame_tick_out);
    // ----------------------------------------------------------------
    // Clock, references and hang guard
    // ----------------------------------------------------------------
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    // Two references with different periods, so a select change forces a new measurement
    always @(negedge mclk_in) begin
        ref_cnt <= ref_cnt + 1;
        pll_ref_in <= (ref_cnt % 20) < 10;
        ext_ref_in <= (ref_cnt % 32) < 16;
    end
    // Whole run needs about 7000 cycles
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge mclk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_write_in = 1'b1;
        @(negedge mclk_in);
        reg_write_in = 1'b0;
        chk("write ack", 16'h0001, {15'h0000, reg_ack_out});
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string name);
        @(negedge mclk_in);
        reg_addr_in = a;
        reg_read_in = 1'b1;
        @(negedge mclk_in);
        reg_read_in = 1'b0;
        chk(name, exp, reg_rdata_out);
    endtask
    // Collect high pins per pin group, so one dead group cannot hide behind another, and count core ticks
    task automatic watch(input int n);
        acc = 16'h0000;
        ticks = 0;
        repeat (n) begin
            @(negedge mclk_in);
            acc = acc | {frame_clock_output_pins_out, bit_clock_output_pins_out,
                         frame_clock_input_pins_out, bit_clock_input_pins_out};
            ticks += core_frame_tick_out;
        end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(negedge mclk_in);
        reset_n_in = 1'b1;
        rd(16'hF050, 16'h0000, "power reset");
        rd(16'hF027, 16'h0000, "lock reset");
        wr(16'hF027, 16'hFFFF);
        rd(16'hF027, 16'h0000, "lock write ignored");
        rd(16'hF051, 16'h0000, "unmapped read");
        wr(16'hF050, 16'hFFFF);
        rd(16'hF050, 16'h1C00, "power readback");
        wr(16'hF050, 16'h0000);
        // Pin 3 stays unrouted; the other three follow generator g
        for (int g = 1; g < 4; g++) begin
            frame_out_sel_in = {2'h0, 2'(g), 2'(g), 2'(g)};
            bit_out_sel_in = {2'h0, 2'(g), 2'(g), 2'(g)};
            frame_in_sel_in = {2'h0, 2'(g), 2'(g), 2'(g)};
            bit_in_sel_in = {2'h0, 2'(g), 2'(g), 2'(g)};
            core_clock_sel_in = 2'(g);
            wr(16'hF050, 16'h0200 << g);
            watch(1700);
            chk("pins running", 16'h7777, acc);
            chk("core running", 16'h0001, {15'h0000, core_run_out});
            chk("frame tick", 16'h0001, {15'h0000, ticks > 0});
            chk("drive enable", 16'h0077, {8'h00, frame_clock_input_pins_oe_out, bit_clock_input_pins_oe_out});
            wr(16'hF050, 16'h0000);
            repeat (3) @(negedge mclk_in);
            watch(200);
            chk("pins stopped", 16'h0000, acc);
            chk("core halted", 16'h0000, {ticks[14:0], core_run_out});
        end
        wr(16'hF050, 16'h1000);
        repeat (400) @(negedge mclk_in);
        rd(16'hF027, 16'h0001, "pll lock");
        hiprec_reference_select_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        rd(16'hF027, 16'h0000, "lock after select change");
        repeat (400) @(negedge mclk_in);
        rd(16'hF027, 16'h0001, "external lock");
        wr(16'hF050, 16'h0000);
        repeat (3) @(negedge mclk_in);
        rd(16'hF027, 16'h0000, "lock after power off");
        close_out();
    end
endmodule // acg_top_tb
`default_nettype wire
